// ---- src/acp_serial_port.sv ----
// serial command port and conversion timing of the converter

package acp_pkg;
  localparam int         BIT_START   = 7;       // start conversion
  localparam int         BIT_MODE    = 6;       // 1: 50 Hz, 0: 60 Hz
  localparam int         BIT_SLEEP   = 5;       // sleep request
  localparam int         BIT_RZERO   = 4;       // read zero
  localparam int         BIT_RS0     = 2;       // readback_sel_lo
  localparam int         BIT_RS1     = 1;       // readback_sel_hi
  localparam int         BIT_DEST    = 0;       // 0: cmd0, 1: cmd1
  localparam int         USER_LSB    = 4;       // cmd1 user outputs lsb
  localparam int         INTEG_60    = 545;     // 60 Hz integrate count
  localparam int         INTEG_50    = 655;     // 50 Hz integrate count
  localparam int         OSC_HZ      = 32768;   // nominal oscillator
  localparam int         CONV_RATE   = 16;      // conversions per second
  localparam int         CONV_PERIOD = OSC_HZ / CONV_RATE;
  localparam int         CNT_W       = 12;      // conversion counter
  localparam logic [3:0] FRAME_BITS  = 4'h8;    // bits in a frame
  localparam logic [1:0] SEL_OUT0    = 2'h0;    // result bits 10..3
  localparam logic [1:0] SEL_OUT1    = 2'h1;    // result bits 18..11
  localparam logic [1:0] SEL_STAT    = 2'h2;    // status register
  localparam logic [7:0] INVALID_OUT = 8'h00;   // reads of code 3
  localparam logic [7:0] CMD0_RST    = 8'h00;   // cmd0 after reset
  localparam logic [3:0] USER_RST    = 4'h0;    // user outputs at reset
  localparam logic [3:0] SYNC_RST    = 4'h9;    // idle pins: osc, cs high
  typedef enum logic [2:0] {
    ACP_IDLE  = 3'h1,  // waiting for start
    ACP_INTEG = 3'h2,  // integrating input
    ACP_DEINT = 3'h4   // deintegrating reference
  } acp_state_t;
endpackage : acp_pkg

`timescale 1ns/100ps
module acp_serial_port #(
  parameter int INTEG_60_CNT = acp_pkg::INTEG_60,    // 60 Hz count
  parameter int INTEG_50_CNT = acp_pkg::INTEG_50,    // 50 Hz count
  parameter int CONV_CNT     = acp_pkg::CONV_PERIOD, // osc per conversion
  parameter int FIFO_DEPTH   = 8                     // command fifo depth
) (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        cs_n,           // chip select pin
  input  wire logic        sclk,           // serial clock pin
  input  wire logic        din,            // serial data in pin
  input  wire logic        osc_input,      // conversion oscillator pin
  input  wire logic [18:0] conv_data,      // result magnitude at end
  input  wire logic        conv_negative,  // result polarity at end
  output logic             dout,           // serial data out
  output logic             dout_oe,        // drive enable for dout
  output logic             eoc,            // end of conversion
  output logic [3:0]       user_out,       // programmed outputs
  output logic             integrating,    // integrate phase active
  output logic             sleep_mode      // sleep bit of cmd0
);
  localparam int CW = acp_pkg::CNT_W;

  // elaboration check on counts
  if (CONV_CNT >= (1 << CW) || INTEG_50_CNT >= CONV_CNT ||
      INTEG_60_CNT >= CONV_CNT || INTEG_60_CNT < 1)
    $error("acp_serial_port conversion counts out of range");

  //////////////////////////////////////////////////////////////////////////
  // pin synchronisers and edge detect
  logic [3:0] sync1_reg;  // first stage: cs, sclk, din, osc
  logic [3:0] sync2_reg;  // second stage
  logic [3:0] prev_reg;   // previous second stage

  // two flops, then one for edges; reset to the idle pin levels so
  // that no false sclk edge follows reset
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      sync1_reg <= acp_pkg::SYNC_RST;
      sync2_reg <= acp_pkg::SYNC_RST;
      prev_reg  <= acp_pkg::SYNC_RST;
    end
    else
    begin
      sync1_reg <= {osc_input, din, sclk, cs_n};
      sync2_reg <= sync1_reg;
      prev_reg  <= sync2_reg;
    end
  end

  wire cs_s      = sync2_reg[0];                 // synced chip select
  wire din_s     = sync2_reg[2];                 // synced data in
  wire cs_fall   = prev_reg[0] && !sync2_reg[0]; // frame opens
  wire cs_rise   = !prev_reg[0] && sync2_reg[0]; // frame closes
  wire sclk_rise = !prev_reg[1] && sync2_reg[1] && !cs_s;
  wire sclk_fall = prev_reg[1] && !sync2_reg[1] && !cs_s;
  wire osc_rise  = !prev_reg[3] && sync2_reg[3]; // one osc period tick

  //////////////////////////////////////////////////////////////////////////
  // receive shifter and bit counter
  logic [7:0] rx_shift_reg;  // incoming command byte
  logic [3:0] bit_cnt_reg;   // bits seen, saturates above eight

  // capture din on sclk rise, msb arrives first
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      rx_shift_reg <= 8'h00;
      bit_cnt_reg  <= 4'h0;
    end
    else if (cs_fall)
      bit_cnt_reg <= 4'h0;
    else if (sclk_rise)
    begin
      rx_shift_reg <= {rx_shift_reg[6:0], din_s};
      if (bit_cnt_reg <= acp_pkg::FRAME_BITS)
        bit_cnt_reg <= bit_cnt_reg + 4'h1;
    end
  end

  // short or long frames are dropped
  wire       frame_ok = bit_cnt_reg == acp_pkg::FRAME_BITS;
  wire       fifo_in_valid = cs_rise && frame_ok;
  wire       fifo_in_ready;
  wire       fifo_out_valid;
  wire [7:0] fifo_out_data;
  logic      start_reg;                    // start waiting for engine
  wire       fifo_out_ready = !start_reg;  // stall while start pending
  wire       cmd_fire = fifo_out_valid && fifo_out_ready;

  // command bytes pass through the fifo in order
  acp_fifo #(
    .WIDTH (8),
    .DEPTH (FIFO_DEPTH)
  ) u_cmd_fifo (
    .clk       (clk),
    .rst       (rst),
    .in_valid  (fifo_in_valid),
    .in_ready  (fifo_in_ready),
    .in_data   (rx_shift_reg),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_out_ready),
    .out_data  (fifo_out_data)
  );

  //////////////////////////////////////////////////////////////////////////
  // command registers
  logic [7:0] cmd0_reg;      // mode, sleep, select, start
  logic [3:0] user_out_reg;  // cmd1 user outputs
  logic       collision_reg; // byte lost to a full fifo

  wire to_cmd1 = fifo_out_data[acp_pkg::BIT_DEST];

  // apply one command per drained byte
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      cmd0_reg     <= acp_pkg::CMD0_RST;
      user_out_reg <= acp_pkg::USER_RST;
    end
    else if (cmd_fire && to_cmd1)
      user_out_reg <= fifo_out_data[7:acp_pkg::USER_LSB];
    else if (cmd_fire)
      cmd0_reg <= fifo_out_data;
  end

  //////////////////////////////////////////////////////////////////////////
  // conversion engine
  acp_pkg::acp_state_t state_reg;  // engine state
  acp_pkg::acp_state_t state_next;
  logic [CW-1:0]       cnt_reg;    // oscillator periods in conversion
  logic [18:0]         result_reg; // last result
  logic                neg_reg;    // last polarity
  logic                eoc_reg;    // conversion finished

  // 50 Hz or 60 Hz integrate length
  wire [CW-1:0] integ_len = cmd0_reg[acp_pkg::BIT_MODE] ?
                            CW'(INTEG_50_CNT) : CW'(INTEG_60_CNT);
  wire integ_done = osc_rise && cnt_reg == integ_len;
  wire conv_done  = osc_rise && cnt_reg == CW'(CONV_CNT - 1);
  wire conv_go    = start_reg && osc_rise;

  // next state
  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      acp_pkg::ACP_IDLE:
        if (conv_go)
          state_next = acp_pkg::ACP_INTEG;
      acp_pkg::ACP_INTEG:
        if (integ_done)
          state_next = acp_pkg::ACP_DEINT;
      acp_pkg::ACP_DEINT:
        if (conv_done)
          state_next = acp_pkg::ACP_IDLE;
      default:
        state_next = acp_pkg::ACP_IDLE;
    endcase
  end

  // state, counter and start flag; start taken only when idle
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      state_reg <= acp_pkg::ACP_IDLE;
      cnt_reg   <= '0;
      start_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      if (state_reg == acp_pkg::ACP_IDLE && conv_go)
      begin
        cnt_reg   <= CW'(1);
        start_reg <= 1'b0;
      end
      else if (cmd_fire && !to_cmd1 && fifo_out_data[acp_pkg::BIT_START])
        start_reg <= 1'b1;
      if (state_reg != acp_pkg::ACP_IDLE && osc_rise)
        cnt_reg <= conv_done ? '0 : cnt_reg + 1'b1;
    end
  end

  // result capture and end flag
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      result_reg <= '0;
      neg_reg    <= 1'b0;
      eoc_reg    <= 1'b0;
    end
    else if (state_reg == acp_pkg::ACP_DEINT && conv_done)
    begin
      result_reg <= conv_data;
      neg_reg    <= conv_negative;
      eoc_reg    <= 1'b1;
    end
    else if (state_reg == acp_pkg::ACP_IDLE && conv_go)
      eoc_reg <= 1'b0;
  end

  //////////////////////////////////////////////////////////////////////////
  // output selection and transmit shifter
  wire [1:0] out_sel = {cmd0_reg[acp_pkg::BIT_RS1],
                        cmd0_reg[acp_pkg::BIT_RS0]};
  wire [7:0] status_byte = {collision_reg, eoc_reg,
                            state_reg == acp_pkg::ACP_INTEG,
                            cmd0_reg[acp_pkg::BIT_SLEEP], neg_reg,
                            result_reg[2:0]};
  wire [7:0] sel_byte =
    (out_sel == acp_pkg::SEL_OUT0) ? result_reg[10:3]  :
    (out_sel == acp_pkg::SEL_OUT1) ? result_reg[18:11] :
    (out_sel == acp_pkg::SEL_STAT) ? status_byte       :
                                     acp_pkg::INVALID_OUT;
  wire stat_read = cs_fall && out_sel == acp_pkg::SEL_STAT;

  // collision: set wins over the clear by a status read
  always_ff @(posedge clk)
  begin
    if (rst)
      collision_reg <= 1'b0;
    else if (fifo_in_valid && !fifo_in_ready)
      collision_reg <= 1'b1;
    else if (stat_read)
      collision_reg <= 1'b0;
  end

  logic [7:0] tx_shift_reg;  // outgoing byte
  logic       dout_reg;      // dout pin value
  logic       dout_oe_reg;   // dout drive enable

  // load on cs fall, shift on sclk fall, msb first
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      tx_shift_reg <= 8'h00;
      dout_reg     <= 1'b0;
      dout_oe_reg  <= 1'b0;
    end
    else if (cs_fall)
    begin
      tx_shift_reg <= sel_byte;
      dout_reg     <= sel_byte[7];
      dout_oe_reg  <= 1'b1;
    end
    else if (cs_rise)
      dout_oe_reg <= 1'b0;
    else if (sclk_fall)
    begin
      tx_shift_reg <= {tx_shift_reg[6:0], 1'b0};
      dout_reg     <= tx_shift_reg[6];
    end
  end

  // registered status outputs
  logic integ_out_reg;  // integrate phase flag
  logic sleep_out_reg;  // sleep flag
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      integ_out_reg <= 1'b0;
      sleep_out_reg <= 1'b0;
    end
    else
    begin
      integ_out_reg <= state_next == acp_pkg::ACP_INTEG;
      sleep_out_reg <= cmd0_reg[acp_pkg::BIT_SLEEP];
    end
  end

  assign dout        = dout_reg;
  assign dout_oe     = dout_oe_reg;
  assign eoc         = eoc_reg;
  assign user_out    = user_out_reg;
  assign integrating = integ_out_reg;
  assign sleep_mode  = sleep_out_reg;

  //////////////////////////////////////////////////////////////////////////
  // checks
  AST_PUSH_EIGHT: assert property (@(posedge clk) disable iff (rst)
    cs_rise && bit_cnt_reg != acp_pkg::FRAME_BITS
    |=> $stable(u_cmd_fifo.wr_ptr_reg))
    else $error("frame without eight bits accepted");
  AST_SHIFT_IN: assert property (@(posedge clk) disable iff (rst)
    sclk_rise && !cs_fall |=> rx_shift_reg[0] == $past(din_s))
    else $error("din not captured on sclk rise");
  AST_DOUT_LOAD: assert property (@(posedge clk) disable iff (rst)
    cs_fall |=> dout_oe && dout == $past(sel_byte[7]))
    else $error("output byte not loaded at cs fall");
  AST_DOUT_SHIFT: assert property (@(posedge clk) disable iff (rst)
    sclk_fall && !cs_fall && !cs_rise |=> dout == $past(tx_shift_reg[6]))
    else $error("dout did not advance on sclk fall");
  AST_OE_OFF: assert property (@(posedge clk) disable iff (rst)
    cs_s && $past(cs_s) |-> !dout_oe)
    else $error("dout driven while cs high");
  AST_CMD0_LOAD: assert property (@(posedge clk) disable iff (rst)
    cmd_fire && !to_cmd1 |=> cmd0_reg == $past(fifo_out_data))
    else $error("cmd0 not loaded from byte with lsb 0");
  AST_CMD1_LOAD: assert property (@(posedge clk) disable iff (rst)
    cmd_fire && to_cmd1 |=> user_out == $past(fifo_out_data[7:4]) &&
    $stable(cmd0_reg))
    else $error("cmd1 byte mishandled");
  AST_INTEG_LEN: assert property (@(posedge clk) disable iff (rst)
    state_reg == acp_pkg::ACP_INTEG && integ_done
    |=> state_reg == acp_pkg::ACP_DEINT)
    else $error("integrate phase length wrong");
  AST_START_CONV: assert property (@(posedge clk) disable iff (rst)
    state_reg == acp_pkg::ACP_IDLE && conv_go
    |=> state_reg == acp_pkg::ACP_INTEG && !start_reg && !eoc)
    else $error("start did not begin a conversion");
  AST_EOC_END: assert property (@(posedge clk) disable iff (rst)
    state_reg == acp_pkg::ACP_DEINT && conv_done
    |=> eoc && state_reg == acp_pkg::ACP_IDLE)
    else $error("conversion end not flagged");
endmodule : acp_serial_port

// ---- src/acp_fifo.sv ----
// small synchronous fifo with valid/ready on both sides
`timescale 1ns/100ps
module acp_fifo #(
  parameter int WIDTH = 8,  // word width
  parameter int DEPTH = 8   // number of words, power of two
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int AW = $clog2(DEPTH);  // pointer width without the wrap bit

  // elaboration check on the depth
  if (DEPTH < 2 || (1 << AW) != DEPTH)
    $error("acp_fifo depth must be a power of two of at least two");

  logic [WIDTH-1:0] mem_reg [DEPTH];  // storage array
  logic [AW:0]      wr_ptr_reg;       // write pointer with wrap bit
  logic [AW:0]      rd_ptr_reg;       // read pointer with wrap bit
  logic             push;             // word accepted
  logic             pop;              // word delivered

  // full when pointers differ only in the wrap bit
  assign in_ready  = (wr_ptr_reg ^ rd_ptr_reg) != {1'b1, {AW{1'b0}}};
  assign out_valid = wr_ptr_reg != rd_ptr_reg;
  assign out_data  = mem_reg[rd_ptr_reg[AW-1:0]];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  // storage write, no reset needed
  always_ff @(posedge clk)
  begin
    if (push)
      mem_reg[wr_ptr_reg[AW-1:0]] <= in_data;
  end

  // pointer update
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
    end
    else
    begin
      if (push)
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      if (pop)
        rd_ptr_reg <= rd_ptr_reg + 1'b1;
    end
  end
endmodule : acp_fifo

// ---- tb/acp_host_model.sv ----
// host model driving frames on the converter's serial port
`timescale 1ns/100ps
module acp_host_model (
  input  wire logic clk,     // system clock, paces the link
  output logic      cs_n,    // chip select, active low
  output logic      sclk,    // link clock, still between frames
  output logic      din,     // command bits to the device
  input  wire logic dout,    // reply bits from the device
  input  wire logic dout_oe  // device drives dout
);
  //////////////////////////////////////////////////////////////////////////
  // idle link: deselected, clock low
  initial
  begin
    cs_n = 1'b1;
    sclk = 1'b0;
    din  = 1'b0;
  end
  // wait n clocks, then step just past the edge
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick
  // send nbits of cmd and collect the reply; cs left low if hold
  task automatic frame(input logic [7:0] cmd, input int nbits,
                       input bit hold, output logic [7:0] rd,
                       output logic oe);
    rd = 8'h00;
    oe = 1'b1;
    cs_n = 1'b0;
    for (int i = 7; i > 7 - nbits; i--)
    begin
      din = cmd[i];        // msb goes first
      tick(4);             // 40 ns low phase
      rd[i] = dout_oe ? dout : ~dout;  // undriven line shows no stale bit
      oe = oe & dout_oe;
      sclk = 1'b1;         // device takes din on this rise
      tick(4);
      sclk = 1'b0;
    end
    din = ~din;            // released line shows no stale value
    tick(4);
    if (!hold)
      end_frame();
  endtask : frame
  // raise chip select and hold the gap between frames
  task automatic end_frame();
    cs_n = 1'b1;
    tick(6);
  endtask : end_frame
endmodule : acp_host_model

// ---- tb/test_adc_serial_command_port.sv ----
// self-checking bench for the converter serial port
`timescale 1ns/100ps
module test_adc_serial_command_port;
  localparam logic [18:0] RES  = 19'h5A5A5;  // result fed to the port
  localparam logic [7:0]  STAT = {5'h09, RES[2:0]}; // eoc, negative
  logic        clk, rst, osc_input, cs_n, sclk, din;    // stimulus
  logic        dout, dout_oe, eoc, integrating, sleep_mode; // outputs
  logic [3:0]  user_out;                                  // user pins
  logic [7:0]  rd;                                        // reply byte
  logic        oe;                                        // oe in frame
  logic [18:0] res_in;                                    // result input
  logic        neg_in;                                    // polarity input
  int          err_count, checks, ni, nc;                 // counters
  // rows: command, reply expected, user outputs after
  logic [7:0]  r_cmd [0:6] = '{8'hA1, 8'h04, 8'h02, 8'h06, 8'h51, 8'h00,
                               8'hF1};
  logic [7:0]  r_rd  [0:6] = '{RES[10:3], RES[10:3], RES[18:11], STAT,
                               8'h00, 8'h00, RES[10:3]};
  logic [3:0]  r_usr [0:6] = '{4'hA, 4'hA, 4'hA, 4'hA, 4'h5, 4'h5, 4'hF};
  //////////////////////////////////////////////////////////////////////////
  // design with short conversion counts
  acp_serial_port #(.INTEG_60_CNT(20), .INTEG_50_CNT(30), .CONV_CNT(40))
  u_dut (.clk(clk), .rst(rst), .cs_n(cs_n), .sclk(sclk), .din(din),
    .osc_input(osc_input), .conv_data(res_in), .conv_negative(neg_in),
    .dout(dout), .dout_oe(dout_oe), .eoc(eoc), .user_out(user_out),
    .integrating(integrating), .sleep_mode(sleep_mode));
  // host side of the link
  acp_host_model u_host (.clk(clk), .cs_n(cs_n), .sclk(sclk), .din(din),
    .dout(dout), .dout_oe(dout_oe));
  //////////////////////////////////////////////////////////////////////////
  // 100 MHz clock and a 1 MHz oscillator
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial
  begin
    osc_input = 1'b0;
    forever #500 osc_input = ~osc_input;
  end
  // compare and count
  task automatic check(input string name, input logic [18:0] seen,
                       input logic [18:0] exp);
    checks++;
    if (seen !== exp)
    begin
      err_count++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  // full frame without hold
  task automatic xfer(input logic [7:0] cmd);
    u_host.frame(cmd, 8, 1'b0, rd, oe);
  endtask : xfer
  // from the start of integration, count osc rises until eoc rises,
  // and those while integrating; outputs read after the edge settles
  task automatic conv_run();
    int   t;
    logic p;
    ni = 0;
    nc = 0;
    t = 0;
    while (integrating !== 1'b1 && t < 9000)
    begin
      u_host.tick(1);
      t++;
    end
    p = osc_input;
    while (eoc !== 1'b1 && t < 9000)
    begin
      u_host.tick(1);
      t++;
      if (osc_input && !p)
      begin
        nc++;
        if (integrating === 1'b1)
          ni++;
      end
      p = osc_input;
    end
    check("conv_end", 19'(eoc), 19'h1);
  endtask : conv_run
  // counts, verdict, end of run
  task automatic final_report();
    $display("counts: %0d checks, %0d mismatches", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : final_report
  //////////////////////////////////////////////////////////////////////////
  // main sequence
  initial
  begin
    err_count = 0;
    checks = 0;
    res_in = RES;
    neg_in = 1'b1;
    rst = 1'b1;
    repeat (2) @(posedge clk);
    #1 rst = 1'b0;
    u_host.tick(1);
    check("reset", 19'({dout_oe, eoc, user_out, integrating, sleep_mode}),
      19'h0);
    u_host.tick(4);
    $display("test reset done");
    // first command initialises; 50 Hz start
    xfer(8'hC0);
    conv_run();
    check("integ_50", 19'(ni), 19'd30);
    check("conv_len", 19'(nc), 19'd39);
    u_host.tick(2500);
    check("eoc_stays", 19'(eoc), 19'h1);
    $display("test conversion done");
    // table rows
    for (int k = 0; k < 7; k++)
    begin
      xfer(r_cmd[k]);
      check("reply", 19'(rd), 19'(r_rd[k]));
      check("user_out", 19'(user_out), 19'(r_usr[k]));
      check("oe_frame", 19'(oe), 19'h1);
      check("oe_idle", 19'(dout_oe), 19'h0);
    end
    $display("test table done");
    // seven bit frame is dropped
    u_host.frame(8'h31, 7, 1'b0, rd, oe);
    check("short", 19'(user_out), 19'hF);
    // no load until chip select rises
    u_host.frame(8'h21, 8, 1'b1, rd, oe);
    u_host.tick(10);
    check("held", 19'(user_out), 19'hF);
    u_host.end_frame();
    check("released", 19'(user_out), 19'h2);
    xfer(8'h20);
    check("sleep", 19'(sleep_mode), 19'h1);
    $display("test frames done");
    // start while busy, then overfill the command fifo
    neg_in = 1'b0;
    xfer(8'h80);
    xfer(8'h80);
    for (int j = 1; j < 10; j++)
      xfer({j[3:0], 4'h1});
    check("stalled", 19'(user_out), 19'h2);
    conv_run();
    conv_run();
    check("integ_60", 19'(ni), 19'd20);
    check("conv_len60", 19'(nc), 19'd39);
    check("drained", 19'(user_out), 19'h8);
    xfer(8'h02);
    xfer(8'h02);
    check("status", 19'(rd), 19'({5'h18, RES[2:0]}));
    xfer(8'h00);
    check("stat_clr", 19'(rd), 19'({5'h08, RES[2:0]}));
    $display("test collision done");
    // reset in mid-run clears the outputs again
    rst = 1'b1;
    u_host.tick(2);
    rst = 1'b0;
    u_host.tick(4);
    check("rst_user", 19'(user_out), 19'h0);
    check("rst_eoc", 19'(eoc), 19'h0);
    check("rst_oe", 19'(dout_oe), 19'h0);
    $display("test mid reset done");
    final_report();
  end
  // watchdog against a hung handshake
  initial
  begin
    #600000;
    err_count++;
    $display("ERROR watchdog expected finish seen hang");
    final_report();
  end
endmodule : test_adc_serial_command_port
